// ===== serial_port_pkg.sv
package serial_port_pkg;
   // Mode encodings, as the two mode select bits read high then low
   localparam logic [1:0] MODE_SHIFT = 2'h0;
   localparam logic [1:0] MODE_ASYNC8 = 2'h1;
   localparam logic [1:0] MODE_FIXED9 = 2'h2;
   localparam logic [1:0] MODE_VAR9 = 2'h3;
   // Oscillator periods per bit
   localparam int SHIFT_DIV = 12;
   localparam int FIXED_DIV_FAST = 32;
   localparam int FIXED_DIV_SLOW = 64;
   // Variable-rate modes take sixteen timer overflows per bit
   localparam int OVF_PER_BIT = 16;
   localparam int SAMPLE_POINT = 8;
   localparam logic [7:0] DATA_RESET = 8'h00;
   localparam logic [3:0] TX_FRAME8 = 4'hA;
   localparam logic [3:0] TX_FRAME9 = 4'hB;
   typedef enum logic [1:0] {TX_IDLE, TX_SEND} tx_state_t;
   typedef enum logic [1:0] {RX_IDLE, RX_SHIFT, RX_FRAME} rx_state_t;
   typedef struct packed {
      logic [1:0] mode;
      logic multiprocessor_filter;
      logic receive_enable;
      logic transmit_ninth_bit;
      logic double_rate;
      logic receive_clock_select;
      logic transmit_clock_select;
   } serial_config_t;
   typedef struct packed {
      logic received_ninth_bit;
      logic transmit_done_flag;
      logic receive_done_flag;
   } serial_status_t;
endpackage

// ===== four_mode_serial_port.sv
`timescale 1ns/100ps
// Overview of operation
// - Transmit and receive run independently, concurrently, except in shift mode, where receive waits for transmit and a write during shift receive is dropped.
// - Receiver shifts while previous byte waits.
// - Unread byte overwritten; one byte lost.
// - Write loads transmitter, read returns receive holding.
// - Shift mode: data on RXD, clock on TXD.
// - Shift mode: eight bits LSB first, osc/12.
// - Async 8-bit: start, eight data, stop.
// - Async 8-bit stores stop bit in ninth.
// - 9-bit: start, eight data, ninth, stop.
// - Transmitted ninth bit comes from control flag.
// - Received ninth bit stored; stop ignored.
// - Fixed 9-bit rate osc/32 or osc/64.
// - Variable 9-bit same as fixed except rate.
// - Shift receive starts when done clear, enabled.
// - Async receive starts on start bit, enabled.
// - With filter, 9-bit done only if ninth set.
// - Filter ignored in shift mode.
// - Async 8-bit with filter needs valid stop.
// - Control holds mode, transmit ninth bit; status holds received ninth bit, done flags.
// - Receive clock from timer2 or timer1 overflow.
// - Transmit clock from timer1 or timer2 overflow.
module four_mode_serial_port (
   input wire logic CORE_CLK,
   input wire logic SYS_RST,
   input wire serial_port_pkg::serial_config_t CONFIG,
   input wire logic [7:0] WRITE_DATA,
   input wire logic WRITE_STROBE,
   input wire logic CLEAR_TRANSMIT_DONE,
   input wire logic CLEAR_RECEIVE_DONE,
   input wire logic TIMER1_OVERFLOW,
   input wire logic TIMER2_OVERFLOW,
   input wire logic RXD_IN,
   output logic RXD_OUT,
   output logic RXD_OE_N,
   output logic TXD,
   output logic [7:0] READ_DATA,
   output serial_port_pkg::serial_status_t STATUS
);
   logic rxd_meta, rxd_sync, rxd_prev;
   always_ff @(posedge CORE_CLK or posedge SYS_RST)
   begin
      if (SYS_RST)
      begin
         rxd_meta <= 1'b1;
         rxd_sync <= 1'b1;
         rxd_prev <= 1'b1;
      end
      else
      begin
         rxd_meta <= RXD_IN;
         rxd_sync <= rxd_meta;
         rxd_prev <= rxd_sync;
      end
   end

   // Bit-rate ticks; async modes run 16 ticks per bit so the receiver can sample mid-bit
   logic [5:0] div_cnt, next_div_cnt;
   logic tick_shift, tick_fixed;
   logic [3:0] shift_cnt, next_shift_cnt;
   always_comb
   begin
      next_div_cnt = div_cnt + 6'h01;
      tick_fixed = 1'b0;
      if ((CONFIG.double_rate && div_cnt == 6'(serial_port_pkg::FIXED_DIV_FAST / 16 - 1))
          || div_cnt == 6'(serial_port_pkg::FIXED_DIV_SLOW / 16 - 1))
      begin
         next_div_cnt = 6'h00;
         tick_fixed = 1'b1;
      end
      next_shift_cnt = shift_cnt + 4'h1;
      tick_shift = 1'b0;
      // Two ticks per shift bit, one for each half of the shift clock
      if (shift_cnt == 4'(serial_port_pkg::SHIFT_DIV / 2 - 1))
      begin
         next_shift_cnt = 4'h0;
         tick_shift = 1'b1;
      end
   end
   always_ff @(posedge CORE_CLK or posedge SYS_RST)
   begin
      if (SYS_RST)
      begin
         div_cnt <= 6'h00;
         shift_cnt <= 4'h0;
      end
      else
      begin
         div_cnt <= next_div_cnt;
         shift_cnt <= next_shift_cnt;
      end
   end

   logic tx_tick, rx_tick;
   logic is_shift;
   always_comb
   begin
      is_shift = CONFIG.mode == serial_port_pkg::MODE_SHIFT;
      unique case (CONFIG.mode)
         serial_port_pkg::MODE_SHIFT:
         begin
            tx_tick = tick_shift;
            rx_tick = tick_shift;
         end
         serial_port_pkg::MODE_FIXED9:
         begin
            tx_tick = tick_fixed;
            rx_tick = tick_fixed;
         end
         default:
         begin
            tx_tick = CONFIG.transmit_clock_select ? TIMER2_OVERFLOW : TIMER1_OVERFLOW;
            rx_tick = CONFIG.receive_clock_select ? TIMER2_OVERFLOW : TIMER1_OVERFLOW;
         end
      endcase
   end

   // Transmitter, independent of the receiver except for the shared TXD clock pin in shift mode
   serial_port_pkg::tx_state_t tx_state, next_tx_state;
   // Receiver state is visible here because the shift receiver owns the clock pin while it runs
   serial_port_pkg::rx_state_t rx_state, next_rx_state;
   logic rx_half, next_rx_half;
   logic [9:0] tx_shreg, next_tx_shreg;
   logic [3:0] tx_bits, next_tx_bits;
   logic [3:0] tx_sub, next_tx_sub;
   logic tx_half, next_tx_half;
   logic next_txd, next_rxd_out, next_rxd_oe_n;
   logic tx_done, next_tx_done, tx_done_set;
   logic tx_bit_end;
   always_comb
   begin
      next_tx_state = tx_state;
      next_tx_shreg = tx_shreg;
      next_tx_bits = tx_bits;
      next_tx_sub = tx_sub;
      next_tx_half = tx_half;
      next_txd = TXD;
      next_rxd_out = RXD_OUT;
      next_rxd_oe_n = RXD_OE_N;
      tx_done_set = 1'b0;
      tx_bit_end = tx_tick && (is_shift || tx_sub == 4'(serial_port_pkg::OVF_PER_BIT - 1));
      unique case (tx_state)
         serial_port_pkg::TX_IDLE:
         begin
            if (rx_state != serial_port_pkg::RX_SHIFT)
               next_txd = 1'b1;
            if (WRITE_STROBE && rx_state != serial_port_pkg::RX_SHIFT)
            begin
               next_tx_state = serial_port_pkg::TX_SEND;
               next_tx_sub = 4'h0;
               next_tx_half = 1'b0;
               if (is_shift)
               begin
                  next_tx_shreg = {2'b11, WRITE_DATA};
                  next_tx_bits = 4'h8;
                  next_rxd_oe_n = 1'b0;
                  next_rxd_out = WRITE_DATA[0];
               end
               else if (CONFIG.mode == serial_port_pkg::MODE_ASYNC8)
               begin
                  next_tx_shreg = {2'b11, WRITE_DATA};
                  next_tx_bits = serial_port_pkg::TX_FRAME8;
                  next_txd = 1'b0;
               end
               else
               begin
                  next_tx_shreg = {1'b1, CONFIG.transmit_ninth_bit, WRITE_DATA};
                  next_tx_bits = serial_port_pkg::TX_FRAME9;
                  next_txd = 1'b0;
               end
            end
         end
         serial_port_pkg::TX_SEND:
         begin
            if (is_shift)
            begin
               // Clock low in the first half of each bit, data shifts on the rising edge
               if (tx_tick)
               begin
                  next_tx_half = ~tx_half;
                  next_txd = tx_half;
                  if (tx_half)
                  begin
                     next_tx_shreg = {1'b1, tx_shreg[9:1]};
                     next_rxd_out = tx_shreg[1];
                     next_tx_bits = tx_bits - 4'h1;
                     if (tx_bits == 4'h1)
                     begin
                        next_tx_state = serial_port_pkg::TX_IDLE;
                        next_rxd_oe_n = 1'b1;
                        next_txd = 1'b1;
                        tx_done_set = 1'b1;
                     end
                  end
               end
            end
            else
            begin
               if (tx_tick)
                  next_tx_sub = tx_sub + 4'h1;
               if (tx_bit_end)
               begin
                  next_tx_bits = tx_bits - 4'h1;
                  next_txd = tx_shreg[0];
                  next_tx_shreg = {1'b1, tx_shreg[9:1]};
                  if (tx_bits == 4'h1)
                  begin
                     next_tx_state = serial_port_pkg::TX_IDLE;
                     next_txd = 1'b1;
                     tx_done_set = 1'b1;
                  end
               end
            end
         end
         default:
            next_tx_state = serial_port_pkg::TX_IDLE;
      endcase
      if (rx_state == serial_port_pkg::RX_SHIFT && rx_tick)
         next_txd = rx_half;
      next_tx_done = tx_done_set | (tx_done & ~CLEAR_TRANSMIT_DONE);
   end
   always_ff @(posedge CORE_CLK or posedge SYS_RST)
   begin
      if (SYS_RST)
      begin
         tx_state <= serial_port_pkg::TX_IDLE;
         tx_shreg <= 10'h3FF;
         tx_bits <= 4'h0;
         tx_sub <= 4'h0;
         tx_half <= 1'b0;
         TXD <= 1'b1;
         RXD_OUT <= 1'b1;
         RXD_OE_N <= 1'b1;
         tx_done <= 1'b0;
      end
      else
      begin
         tx_state <= next_tx_state;
         tx_shreg <= next_tx_shreg;
         tx_bits <= next_tx_bits;
         tx_sub <= next_tx_sub;
         tx_half <= next_tx_half;
         TXD <= next_txd;
         RXD_OUT <= next_rxd_out;
         RXD_OE_N <= next_rxd_oe_n;
         tx_done <= next_tx_done;
      end
   end

   // Receiver; holding register is loaded only at frame end, so shifting overlaps an unread byte
   logic [8:0] rx_shreg, next_rx_shreg;
   logic [3:0] rx_bits, next_rx_bits;
   logic [3:0] rx_sub, next_rx_sub;
   logic [7:0] rx_hold, next_rx_hold;
   logic ninth_rx, next_ninth_rx;
   logic rx_done, next_rx_done, rx_done_set;
   logic sample, frame_len9;
   always_comb
   begin
      next_rx_state = rx_state;
      next_rx_shreg = rx_shreg;
      next_rx_bits = rx_bits;
      next_rx_sub = rx_sub;
      next_rx_hold = rx_hold;
      next_rx_half = rx_half;
      next_ninth_rx = ninth_rx;
      rx_done_set = 1'b0;
      frame_len9 = CONFIG.mode[1];
      sample = rx_tick && rx_sub == 4'(serial_port_pkg::SAMPLE_POINT - 1);
      unique case (rx_state)
         serial_port_pkg::RX_IDLE:
         begin
            if (is_shift && CONFIG.receive_enable && !rx_done && tx_state == serial_port_pkg::TX_IDLE
                && !WRITE_STROBE)
            begin
               next_rx_state = serial_port_pkg::RX_SHIFT;
               next_rx_half = 1'b0;
               next_rx_bits = 4'h8;
               next_rx_sub = 4'h0;
            end
            else if (!is_shift && CONFIG.receive_enable && rxd_prev && !rxd_sync)
            begin
               next_rx_state = serial_port_pkg::RX_FRAME;
               next_rx_bits = frame_len9 ? serial_port_pkg::TX_FRAME9 : serial_port_pkg::TX_FRAME8;
               next_rx_sub = 4'h0;
            end
         end
         serial_port_pkg::RX_SHIFT:
         begin
            // Shift clock toggles each tick; RXD is sampled at its rising edge, LSB first
            if (rx_tick)
            begin
               next_rx_half = ~rx_half;
               if (rx_half)
               begin
                  next_rx_shreg = {rxd_sync, rx_shreg[8:1]};
                  next_rx_bits = rx_bits - 4'h1;
                  if (rx_bits == 4'h1)
                  begin
                     next_rx_state = serial_port_pkg::RX_IDLE;
                     next_rx_hold = {rxd_sync, rx_shreg[8:2]};
                     rx_done_set = 1'b1;
                  end
               end
            end
         end
         serial_port_pkg::RX_FRAME:
         begin
            if (rx_tick)
               next_rx_sub = rx_sub + 4'h1;
            if (sample)
            begin
               next_rx_bits = rx_bits - 4'h1;
               if (rx_bits == (frame_len9 ? serial_port_pkg::TX_FRAME9 : serial_port_pkg::TX_FRAME8)
                   && rxd_sync)
                  next_rx_state = serial_port_pkg::RX_IDLE; // False start glitch
               else if (rx_bits == 4'h1)
               begin
                  next_rx_state = serial_port_pkg::RX_IDLE;
                  if (frame_len9)
                  begin
                     // Stop bit ignored; ninth bit in rx_shreg[8]
                     if (!CONFIG.multiprocessor_filter || rx_shreg[8])
                     begin
                        next_rx_hold = rx_shreg[7:0];
                        next_ninth_rx = rx_shreg[8];
                        rx_done_set = 1'b1;
                     end
                  end
                  else if (!CONFIG.multiprocessor_filter || rxd_sync)
                  begin
                     next_rx_hold = rx_shreg[8:1];
                     next_ninth_rx = rxd_sync;
                     rx_done_set = 1'b1;
                  end
               end
               else if (rx_bits != (frame_len9 ? serial_port_pkg::TX_FRAME9 : serial_port_pkg::TX_FRAME8))
                  next_rx_shreg = {rxd_sync, rx_shreg[8:1]};
            end
         end
         default:
            next_rx_state = serial_port_pkg::RX_IDLE;
      endcase
      next_rx_done = rx_done_set | (rx_done & ~CLEAR_RECEIVE_DONE);
   end
   always_ff @(posedge CORE_CLK or posedge SYS_RST)
   begin
      if (SYS_RST)
      begin
         rx_state <= serial_port_pkg::RX_IDLE;
         rx_shreg <= 9'h000;
         rx_bits <= 4'h0;
         rx_sub <= 4'h0;
         rx_hold <= serial_port_pkg::DATA_RESET;
         ninth_rx <= 1'b0;
         rx_done <= 1'b0;
         rx_half <= 1'b0;
      end
      else
      begin
         rx_state <= next_rx_state;
         rx_shreg <= next_rx_shreg;
         rx_bits <= next_rx_bits;
         rx_sub <= next_rx_sub;
         rx_hold <= next_rx_hold;
         ninth_rx <= next_ninth_rx;
         rx_done <= next_rx_done;
         rx_half <= next_rx_half;
      end
   end

   always_comb
   begin
      READ_DATA = rx_hold;
      STATUS = '{received_ninth_bit: ninth_rx, transmit_done_flag: tx_done, receive_done_flag: rx_done};
   end
endmodule // four_mode_serial_port

// ===== serial_port_chk.sv
`timescale 1ns/100ps
module serial_port_chk (
   input wire logic CORE_CLK,
   input wire logic SYS_RST,
   input wire serial_port_pkg::serial_config_t CONFIG,
   input wire logic CLEAR_TRANSMIT_DONE,
   input wire logic CLEAR_RECEIVE_DONE,
   input wire logic RXD_OE_N,
   input wire logic TXD,
   input wire logic [7:0] READ_DATA,
   input wire serial_port_pkg::serial_status_t STATUS
);
   default clocking @(posedge CORE_CLK); endclocking
   default disable iff (SYS_RST);
   // Low half of a twelve-clock shift bit
   sequence low_half;
      (!TXD) [*6];
   endsequence
   sequence rx_taken;
      $rose(STATUS.receive_done_flag);
   endsequence
   a_oe_shift: assert property (!RXD_OE_N |-> CONFIG.mode == serial_port_pkg::MODE_SHIFT)
      else $error("data pin driven outside shift mode");
   a_shift_half: assert property ($fell(TXD) && CONFIG.mode == serial_port_pkg::MODE_SHIFT |-> low_half ##1 TXD)
      else $error("shift clock low half not six clocks");
   a_tx_done_idle: assert property ($rose(STATUS.transmit_done_flag) |-> TXD)
      else $error("transmit done with line not idle");
   a_td_sticky: assert property (STATUS.transmit_done_flag && !CLEAR_TRANSMIT_DONE |=> STATUS.transmit_done_flag)
      else $error("transmit done dropped without clear");
   a_rd_sticky: assert property (STATUS.receive_done_flag && !CLEAR_RECEIVE_DONE |=> STATUS.receive_done_flag)
      else $error("receive done dropped without clear");
   a_data_cause: assert property ($changed(READ_DATA) |-> ##[0:1] STATUS.receive_done_flag)
      else $error("receive data changed without done flag");
   a_ninth_cause: assert property ($changed(STATUS.received_ninth_bit) |-> ##[0:1] STATUS.receive_done_flag)
      else $error("ninth bit changed without done flag");
   a_addr_only: assert property (rx_taken and CONFIG.multiprocessor_filter && CONFIG.mode[1]
      |-> ##[0:1] STATUS.received_ninth_bit)
      else $error("filtered frame accepted with ninth bit low");
   a_stop_valid: assert property (rx_taken and CONFIG.multiprocessor_filter
      && CONFIG.mode == serial_port_pkg::MODE_ASYNC8 |-> ##[0:1] STATUS.received_ninth_bit)
      else $error("filtered frame accepted with bad stop");
endmodule // serial_port_chk
bind four_mode_serial_port serial_port_chk chk (.CORE_CLK(CORE_CLK), .SYS_RST(SYS_RST), .CONFIG(CONFIG),
   .CLEAR_TRANSMIT_DONE(CLEAR_TRANSMIT_DONE), .CLEAR_RECEIVE_DONE(CLEAR_RECEIVE_DONE), .RXD_OE_N(RXD_OE_N),
   .TXD(TXD), .READ_DATA(READ_DATA), .STATUS(STATUS));

// ===== serial_node.sv
`timescale 1ns/100ps
module serial_node (
   input wire logic clk,
   input wire logic txd,
   output logic line
);
   // Released line rests high, as its pull-up leaves it
   initial line = 1'h1;
   task automatic send(input logic [10:0] bits, input int n, input int p);
      for (int i = 0; i < n; i++)
      begin
         line = bits[i];
         repeat (p) @(posedge clk);
         #1;
      end
      line = 1'h1;
   endtask
   task automatic grab(input int n, input int p, output logic [10:0] bits);
      bits = '1;
      @(negedge txd);
      repeat (p / 2) @(posedge clk);
      for (int i = 0; i < n; i++)
      begin
         bits[i] = txd;
         repeat (p) @(posedge clk);
      end
   endtask
   task automatic shift_in(input logic [7:0] b);
      for (int i = 0; i < 8; i++)
      begin
         @(negedge txd);
         #1 line = b[i];
      end
      @(posedge txd);
      #1 line = 1'h1;
   endtask
endmodule // serial_node

// ===== tb_top.sv
`timescale 1ns/100ps
module tb_top;
   typedef struct packed {
      logic [1:0] mode;
      logic dr;
      logic rsel;
      logic tsel;
      logic [7:0] data;
      logic ninth;
   } row_t;
   row_t rows [6] = '{'{2'h1, 1'h0, 1'h0, 1'h0, 8'hA5, 1'h0}, '{2'h1, 1'h0, 1'h1, 1'h0, 8'h3C, 1'h0},
      '{2'h2, 1'h1, 1'h0, 1'h0, 8'h5A, 1'h1}, '{2'h2, 1'h0, 1'h0, 1'h0, 8'hC3, 1'h0},
      '{2'h3, 1'h0, 1'h0, 1'h1, 8'h81, 1'h1}, '{2'h3, 1'h0, 1'h1, 1'h0, 8'h7E, 1'h0}};
   row_t r;
   logic clk, rst, strobe, clr_t, clr_r, rxd_out, oe_n, txd, line, rxd_in;
   logic [7:0] wdata, rdata, b, o;
   logic [1:0] tcnt = 2'h0;
   logic [10:0] f, got;
   int n;
   int fail_count = 0;
   int tests_run = 0;
   serial_port_pkg::serial_config_t cfg;
   serial_port_pkg::serial_status_t st;
   // Timer 1 ticks every 2 clocks, timer 2 every 4, so a wrong source doubles or halves the bit
   always @(posedge clk) tcnt <= tcnt + 2'h1;
   assign rxd_in = oe_n ? line : rxd_out;
   four_mode_serial_port uut (.CORE_CLK(clk), .SYS_RST(rst), .CONFIG(cfg), .WRITE_DATA(wdata), .WRITE_STROBE(strobe),
      .CLEAR_TRANSMIT_DONE(clr_t), .CLEAR_RECEIVE_DONE(clr_r), .TIMER1_OVERFLOW(tcnt[0]), .TIMER2_OVERFLOW(&tcnt),
      .RXD_IN(rxd_in), .RXD_OUT(rxd_out), .RXD_OE_N(oe_n), .TXD(txd), .READ_DATA(rdata), .STATUS(st));
   serial_node node (.clk(clk), .txd(txd), .line(line));
   function automatic int per(row_t x, logic sel);
      if (x.mode == serial_port_pkg::MODE_FIXED9)
         return x.dr ? 32 : 64;
      return sel ? 64 : 32;
   endfunction
   task automatic check(input logic [15:0] seen, input logic [15:0] exp);
      tests_run++;
      if (seen !== exp)
      begin
         fail_count++;
         $display("[ERR] %0t seen %h expected %h", $time, seen, exp);
      end
   endtask
   task automatic wrap_up;
      $display("mismatches %0d comparisons %0d", fail_count, tests_run);
      if (fail_count == 0 && tests_run > 0)
         $display("verification passed");
      else
         $display("verification failed");
      $finish;
   endtask
   task automatic write(input logic [7:0] d);
      @(posedge clk);
      #1 wdata = d;
      strobe = 1'h1;
      @(posedge clk);
      #1 strobe = 1'h0;
   endtask
   task automatic clear;
      @(posedge clk);
      #1 clr_t = 1'h1;
      clr_r = 1'h1;
      @(posedge clk);
      #1 clr_t = 1'h0;
      clr_r = 1'h0;
   endtask
   task automatic recv(input logic [10:0] fr, input int k, input logic [10:0] exp);
      node.send(fr, k, 32);
      repeat (4) @(posedge clk);
      check({st, rdata}, exp);
   endtask
   initial
   begin
      clk = 1'h0;
      forever #2.5 clk = ~clk;
   end
   initial
   begin
      repeat (30000) @(posedge clk);
      fail_count++;
      wrap_up;
   end
   initial
   begin
      rst = 1'h1;
      strobe = 1'h0;
      clr_t = 1'h0;
      clr_r = 1'h0;
      wdata = 8'h00;
      cfg = '0;
      repeat (16) @(posedge clk);
      check({txd, oe_n, rxd_out, st, rdata}, {3'h7, 3'h0, 8'h00});
      #1 rst = 1'h0;
      foreach (rows[i])
      begin
         r = rows[i];
         cfg = '{r.mode, 1'h0, 1'h1, r.ninth, r.dr, r.rsel, r.tsel};
         n = r.mode == serial_port_pkg::MODE_ASYNC8 ? 10 : 11;
         f = n == 10 ? {2'h3, r.data, 1'h0} : {1'h1, r.ninth, r.data, 1'h0};
         fork
            write(r.data);
            node.grab(n, per(r, r.tsel), got);
            node.send(f, n, per(r, r.rsel));
         join
         check(got, f);
         check({st, rdata}, {f[9], 2'h3, r.data});
         clear;
      end
      cfg = '{2'h1, 1'h0, 1'h1, 1'h0, 1'h0, 1'h0, 1'h0};
      recv({2'h3, 8'h11, 1'h0}, 10, {3'h5, 8'h11});
      recv({2'h3, 8'h22, 1'h0}, 10, {3'h5, 8'h22});
      clear;
      cfg.multiprocessor_filter = 1'h1;
      recv({2'h0, 8'h44, 1'h0}, 10, {3'h4, 8'h22});
      recv({2'h3, 8'h55, 1'h0}, 10, {3'h5, 8'h55});
      clear;
      cfg = '{2'h2, 1'h1, 1'h1, 1'h0, 1'h1, 1'h0, 1'h0};
      recv({2'h2, 8'h66, 1'h0}, 11, {3'h4, 8'h55});
      recv({2'h3, 8'h09, 1'h0}, 11, {3'h5, 8'h09});
      clear;
      cfg.multiprocessor_filter = 1'h0;
      recv({2'h2, 8'h77, 1'h0}, 11, {3'h1, 8'h77});
      clear;
      recv({2'h1, 8'h78, 1'h0}, 11, {3'h5, 8'h78});
      clear;
      cfg = '{2'h0, 1'h1, 1'h0, 1'h0, 1'h0, 1'h0, 1'h0};
      fork
         write(8'hB4);
         for (int i = 0; i < 8; i++)
         begin
            @(negedge txd);
            b[i] = rxd_out;
            o[i] = oe_n;
         end
      join
      repeat (30) @(posedge clk);
      check({o, b}, {8'h00, 8'hB4});
      check({oe_n, st[1:0]}, 3'h6);
      clear;
      cfg.receive_enable = 1'h1;
      node.shift_in(8'h6D);
      repeat (30) @(posedge clk);
      check({st[0], rdata}, {1'h1, 8'h6D});
      cfg.receive_enable = 1'h0;
      wrap_up;
   end
endmodule // tb_top
